// *** design/als_core.v ***
// Accumulator logic and subtract-with-borrow execution slice
//
// Implementation choices: the plain strobed port and the register addresses.
`include "als_regs.vh"
`default_nettype none

module als_core (
  // Clock, reset, enable
  input  wire        clock,
  input  wire        rst,
  input  wire        ce,
  // Register port
  input  wire [3:0]  reg_addr,
  input  wire [7:0]  reg_wdata,
  input  wire        reg_write,
  input  wire        reg_read,
  output reg  [7:0]  reg_rdata,
  // Byte supply from fetch and memory-read sequencing
  output wire        byte_req,
  output wire        byte_from_mem,
  output reg  [15:0] mem_addr,
  input  wire        byte_valid,
  input  wire [7:0]  byte_data,
  // Execution status
  output wire        busy,
  output reg         retire,
  output reg         unsupported,
  output reg  [7:0]  acc_out,
  output reg  [7:0]  flags_out,
  output reg  [2:0]  last_mcycles,
  output reg  [7:0]  last_tstates
);

  // ----------------------------------------------------------------
  // Machine-cycle states
  // ----------------------------------------------------------------
  localparam [2:0] S_M1   = 3'd0;   // Opcode or prefix fetch
  localparam [2:0] S_M1X  = 3'd1;   // Opcode fetch after index prefix
  localparam [2:0] S_RD   = 3'd2;   // Immediate, pointer or displacement read
  localparam [2:0] S_ADDR = 3'd3;   // Index address formation
  localparam [2:0] S_MEM  = 3'd4;   // Indexed memory operand read

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  reg  [7:0]  gp [0:5];     // B, C, D, E, H, L by register code
  reg  [15:0] idx_one;      // index_register_one
  reg  [15:0] idx_two;      // index_register_two
  reg  [2:0]  state;        // Current machine cycle
  reg  [2:0]  tcnt;         // Clock state within machine cycle, from 1
  reg  [2:0]  mtot;         // Machine cycles finished this instruction
  reg  [7:0]  ttot;         // Clock states spent this instruction
  reg  [2:0]  op_q;         // Latched operation field
  reg         ptr_mode;     // Operand read addresses pointer_pair
  reg         idx_mode;     // Indexed form in progress
  reg         idx_sel;      // High selects index_register_two
  reg         run;          // Control: allow new instructions
  reg         unsup_sticky; // Status: an unsupported opcode was seen
  integer     i;            // Reset loop index

  // ----------------------------------------------------------------
  // Machine-cycle timing
  // ----------------------------------------------------------------
  reg  [2:0]  mlen;         // Clock states in current machine cycle
  wire        last_t;       // Final clock state of the machine cycle
  wire        need_byte;    // Machine cycle ends on a byte
  wire        take;         // Byte accepted this cycle
  wire        idle_wait;    // Parked at the first state, not running
  wire        advance;      // Clock state counts this cycle

  // Lengths per machine cycle: fetch 4, read 3, address 5
  always @* begin
    case (state)
      S_M1:    mlen = `ALS_T_FETCH;
      S_M1X:   mlen = `ALS_T_FETCH;
      S_ADDR:  mlen = `ALS_T_ADDR;
      default: mlen = `ALS_T_READ;
    endcase
  end

  assign last_t        = (tcnt == mlen);
  assign need_byte     = (state != S_ADDR);
  assign byte_req      = last_t & need_byte;
  // Memory side for pointer reads and the indexed operand read
  assign byte_from_mem = (state == S_MEM) | ((state == S_RD) & ptr_mode & ~idx_mode);
  assign take          = byte_req & byte_valid;
  // A late byte stretches the final state, like a wait state
  assign idle_wait     = (state == S_M1) & (tcnt == 3'd1) & ~run;
  assign advance       = ~idle_wait & ~(byte_req & ~byte_valid);
  assign busy          = ~((state == S_M1) & (tcnt == 3'd1));

  // ----------------------------------------------------------------
  // Opcode decode of the byte on offer
  // ----------------------------------------------------------------
  wire [1:0]  grp;          // Top two opcode bits
  wire [2:0]  fld;          // Operation field
  wire [2:0]  rcode;        // Register code in low bits
  wire        ours;         // Field names one of the four operations
  wire        is_prefix;    // Index prefix byte
  wire        is_reg;       // Register form
  wire        is_ptr;       // Pointer-indirect form, also indexed opcode
  wire        is_imm;       // Immediate form

  assign grp       = byte_data[7:6];
  assign fld       = byte_data[5:3];
  assign rcode     = byte_data[2:0];
  // Subtract, AND, exclusive-OR and OR only
  assign ours      = (fld == `ALS_OP_SBC) | (fld == `ALS_OP_AND) |
                     (fld == `ALS_OP_XOR) | (fld == `ALS_OP_OR);
  assign is_prefix = (byte_data == `ALS_PFX_IDX1) |
                     (byte_data == `ALS_PFX_IDX2);
  assign is_reg    = (grp == `ALS_GRP_REG) & ours & (rcode != `ALS_SRC_MEM);
  assign is_ptr    = (grp == `ALS_GRP_REG) & ours & (rcode == `ALS_SRC_MEM);
  assign is_imm    = (grp == `ALS_GRP_IMM) & ours & (rcode == `ALS_SRC_MEM);

  // ----------------------------------------------------------------
  // Operand selection
  // ----------------------------------------------------------------
  reg  [7:0]  reg_opnd;     // Register named by the low opcode bits
  wire [7:0]  alu_opnd;     // Operand for the operation
  wire [2:0]  alu_op;       // Operation in force
  wire [7:0]  alu_res;      // Operation result
  wire [7:0]  alu_flags;    // Flags from the operation

  // Code 110 means a memory operand: it gives 00 here and is never executed
  always @* begin
    if (rcode == `ALS_R_A) begin
      reg_opnd = acc_out;
    end else if (rcode == `ALS_SRC_MEM) begin
      reg_opnd = 8'h00;
    end else begin
      reg_opnd = gp[rcode];
    end
  end

  // Register form executes on the opcode byte itself
  assign alu_opnd = (state == S_M1) ? reg_opnd : byte_data;
  assign alu_op   = (state == S_M1) ? fld : op_q;

  als_alu u_alu (
    .op       (alu_op),
    .acc      (acc_out),
    .opnd     (alu_opnd),
    .carry_in (flags_out[`ALS_F_C]),
    .result   (alu_res),
    .flags    (alu_flags)
  );

  // ----------------------------------------------------------------
  // Execution and address formation
  // ----------------------------------------------------------------
  wire        exec;         // Write result and flags this cycle
  wire        done;         // Instruction ends this cycle
  wire        bad;          // Opcode outside this slice
  wire [15:0] idx_base;     // Selected index register
  wire [15:0] disp_ext;     // Sign-extended displacement
  wire [15:0] pointer_pair; // H and L as one address

  assign exec = take & (((state == S_M1) & is_reg) |
                        ((state == S_RD) & ~idx_mode) |
                        (state == S_MEM));
  assign bad  = take & (((state == S_M1) & ~is_prefix & ~is_reg & ~is_ptr & ~is_imm) |
                        ((state == S_M1X) & ~is_ptr));
  assign done = exec | bad;

  assign idx_base     = idx_sel ? idx_two : idx_one;
  assign disp_ext     = {{8{byte_data[7]}}, byte_data};
  assign pointer_pair = {gp[`ALS_R_H], gp[`ALS_R_L]};

  // ----------------------------------------------------------------
  // Register port read
  // ----------------------------------------------------------------
  reg  [7:0]  rd_mux;       // Value presented for a read

  always @* begin
    case (reg_addr)
      `ALS_A_F:      rd_mux = flags_out;
      `ALS_A_A:      rd_mux = acc_out;
      `ALS_A_IX1_LO: rd_mux = idx_one[7:0];
      `ALS_A_IX1_HI: rd_mux = idx_one[15:8];
      `ALS_A_IX2_LO: rd_mux = idx_two[7:0];
      `ALS_A_IX2_HI: rd_mux = idx_two[15:8];
      `ALS_A_CTRL:   rd_mux = {7'h00, run};
      `ALS_A_STATUS: rd_mux = {6'h00, unsup_sticky, busy};
      `ALS_A_LAST_M: rd_mux = {5'h00, last_mcycles};
      `ALS_A_LAST_T: rd_mux = last_tstates;
      default: begin
        // Addresses 0 to 5 are the general registers
        rd_mux = gp[reg_addr[2:0]];
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Sequencer, register file and accumulator
  // ----------------------------------------------------------------
  // Machine results override a software write to A or F in the same cycle
  always @(posedge clock) begin
    if (rst) begin
      for (i = 0; i < 6; i = i + 1) begin
        gp[i] <= `ALS_RST_BYTE;
      end
      idx_one      <= `ALS_RST_WORD;
      idx_two      <= `ALS_RST_WORD;
      acc_out      <= `ALS_RST_BYTE;
      flags_out    <= `ALS_RST_BYTE;
      state        <= S_M1;
      tcnt         <= 3'd1;
      mtot         <= 3'd0;
      ttot         <= 8'h00;
      op_q         <= 3'd0;
      ptr_mode     <= 1'b0;
      idx_mode     <= 1'b0;
      idx_sel      <= 1'b0;
      mem_addr     <= `ALS_RST_WORD;
      run          <= 1'b0;
      unsup_sticky <= 1'b0;
      retire       <= 1'b0;
      unsupported  <= 1'b0;
      last_mcycles <= 3'd0;
      last_tstates <= 8'h00;
      reg_rdata    <= 8'h00;
    end else if (ce) begin
      // Read data stand for one cycle only
      reg_rdata   <= reg_read ? rd_mux : 8'h00;
      retire      <= done;
      unsupported <= bad;
      // Software writes
      if (reg_write) begin
        case (reg_addr)
          `ALS_A_F:      flags_out     <= reg_wdata;
          `ALS_A_A:      acc_out       <= reg_wdata;
          `ALS_A_IX1_LO: idx_one[7:0]  <= reg_wdata;
          `ALS_A_IX1_HI: idx_one[15:8] <= reg_wdata;
          `ALS_A_IX2_LO: idx_two[7:0]  <= reg_wdata;
          `ALS_A_IX2_HI: idx_two[15:8] <= reg_wdata;
          `ALS_A_CTRL:   run           <= reg_wdata[`ALS_CTRL_RUN];
          `ALS_A_STATUS: begin
            // Write one to clear; a new event below still wins
            if (reg_wdata[`ALS_ST_UNSUP]) begin
              unsup_sticky <= 1'b0;
            end
          end
          `ALS_A_LAST_M: begin
            // Read only
          end
          `ALS_A_LAST_T: begin
            // Read only
          end
          default: begin
            gp[reg_addr[2:0]] <= reg_wdata;
          end
        endcase
      end
      if (bad) begin
        unsup_sticky <= 1'b1;
      end
      // Result write-back to the accumulator
      if (exec) begin
        acc_out   <= alu_res;
        flags_out <= alu_flags;
      end
      // Clock-state and machine-cycle stepping
      if (advance) begin
        ttot <= ttot + 8'h01;
        if (!last_t) begin
          tcnt <= tcnt + 3'd1;
        end else begin
          tcnt <= 3'd1;
          mtot <= mtot + 3'd1;
          case (state)
            S_M1: begin
              if (is_prefix) begin
                idx_sel <= (byte_data == `ALS_PFX_IDX2);
                state   <= S_M1X;
              end else if (is_ptr | is_imm) begin
                op_q     <= fld;
                ptr_mode <= is_ptr;
                idx_mode <= 1'b0;
                mem_addr <= pointer_pair;
                state    <= S_RD;
              end
            end
            S_M1X: begin
              if (is_ptr) begin
                op_q     <= fld;
                idx_mode <= 1'b1;
                state    <= S_RD;
              end
            end
            S_RD: begin
              if (idx_mode) begin
                mem_addr <= idx_base + disp_ext;
                state    <= S_ADDR;
              end
            end
            S_ADDR: begin
              state <= S_MEM;
            end
            S_MEM: begin
              state <= S_M1;
            end
            default: begin
              state <= S_M1;
            end
          endcase
          // Record the totals and park for the next opcode
          if (done) begin
            state        <= S_M1;
            mtot         <= 3'd0;
            ttot         <= 8'h00;
            last_mcycles <= mtot + 3'd1;
            last_tstates <= ttot + 8'h01;
          end
        end
      end
    end
  end

endmodule
`default_nettype wire

// *** inc/als_regs.vh ***
// Constants of the accumulator logic and subtract datapath slice
//
// What this block does
// - Subtract operand and carry_in from accumulator
// - Decode subtract in register, immediate, pointer, indexed forms
// - Low three bits select B,C,D,E,H,L,A
// - Operand from register, immediate, pointer_pair or index
// - Displacement is signed, added to index register
// - AND stores accumulator AND operand
// - OR stores accumulator OR operand
// - Exclusive-OR stores accumulator XOR operand, five forms
// - Cycles: 1/4, 2/7 (4,3), 5/19 (4,4,3,5,3)
// - Sign and zero flags follow the result
// - Subtract: half-borrow bit 4, subtract flag, borrow carry
// - Subtract clears carry when no borrow
// - AND sets half-carry, clears subtract and carry
// - OR clears half, subtract, carry; parity from result
// - Exclusive-OR clears half, subtract, carry; even parity
`ifndef ALS_REGS_VH
`define ALS_REGS_VH

// ----------------------------------------------------------------
// Opcode fields
// ----------------------------------------------------------------
`define ALS_PFX_IDX1    8'hdd
`define ALS_PFX_IDX2    8'hfd
`define ALS_GRP_REG     2'b10
`define ALS_GRP_IMM     2'b11
`define ALS_SRC_MEM     3'b110
`define ALS_OP_SBC      3'b011
`define ALS_OP_AND      3'b100
`define ALS_OP_XOR      3'b101
`define ALS_OP_OR       3'b110

// ----------------------------------------------------------------
// Register codes and register file
// ----------------------------------------------------------------
`define ALS_R_H         3'b100
`define ALS_R_L         3'b101
`define ALS_R_A         3'b111
`define ALS_RST_BYTE    8'h00
`define ALS_RST_WORD    16'h0000

// ----------------------------------------------------------------
// Flag positions in the flag byte
// ----------------------------------------------------------------
`define ALS_F_S         7
`define ALS_F_Z         6
`define ALS_F_H         4
`define ALS_F_PV        2
`define ALS_F_N         1
`define ALS_F_C         0

// ----------------------------------------------------------------
// Clock states per machine cycle
// ----------------------------------------------------------------
`define ALS_T_FETCH     3'd4
`define ALS_T_READ      3'd3
`define ALS_T_ADDR      3'd5

// ----------------------------------------------------------------
// Register port addresses and fields
// ----------------------------------------------------------------
`define ALS_A_F         4'h6
`define ALS_A_A         4'h7
`define ALS_A_IX1_LO    4'h8
`define ALS_A_IX1_HI    4'h9
`define ALS_A_IX2_LO    4'ha
`define ALS_A_IX2_HI    4'hb
`define ALS_A_CTRL      4'hc
`define ALS_A_STATUS    4'hd
`define ALS_A_LAST_M    4'he
`define ALS_A_LAST_T    4'hf
`define ALS_CTRL_RUN    0
`define ALS_ST_BUSY     0
`define ALS_ST_UNSUP    1

`endif

// *** design/als_alu.v ***
// Combinational result and flag generator for the four operations
`include "als_regs.vh"
`default_nettype none

module als_alu (
  // Operation select
  input  wire [2:0] op,
  // Operands
  input  wire [7:0] acc,
  input  wire [7:0] opnd,
  input  wire       carry_in,
  // Result
  output reg  [7:0] result,
  output reg  [7:0] flags
);

  // ----------------------------------------------------------------
  // Subtract with borrow arithmetic
  // ----------------------------------------------------------------
  wire [8:0] diff_full;   // Nine bits, top bit is the borrow out
  wire [4:0] diff_low;    // Low nibble, top bit is borrow from bit 4
  assign diff_full = {1'b0, acc} - {1'b0, opnd} - {8'h00, carry_in};
  assign diff_low  = {1'b0, acc[3:0]} - {1'b0, opnd[3:0]} - {4'h0, carry_in};

  // ----------------------------------------------------------------
  // Result and flag selection
  // ----------------------------------------------------------------
  // Unused flag bits read as zero
  always @* begin
    result = 8'h00;
    flags  = 8'h00;
    case (op)
      `ALS_OP_SBC: begin
        result              = diff_full[7:0];
        flags[`ALS_F_H]     = diff_low[4];
        flags[`ALS_F_N]     = 1'b1;
        flags[`ALS_F_C]     = diff_full[8];
        // Overflow only when signs differ and result sign leaves acc
        flags[`ALS_F_PV]    = (acc[7] ^ opnd[7]) & (acc[7] ^ diff_full[7]);
      end
      `ALS_OP_AND: begin
        result              = acc & opnd;
        flags[`ALS_F_H]     = 1'b1;
        flags[`ALS_F_PV]    = ~^(acc & opnd);
      end
      `ALS_OP_OR: begin
        result              = acc | opnd;
        flags[`ALS_F_PV]    = ~^(acc | opnd);
      end
      `ALS_OP_XOR: begin
        result              = acc ^ opnd;
        flags[`ALS_F_PV]    = ~^(acc ^ opnd);
      end
      default: begin
        result = acc;
      end
    endcase
    // Sign and zero common to all four operations
    flags[`ALS_F_S] = result[7];
    flags[`ALS_F_Z] = (result == 8'h00);
  end

endmodule
`default_nettype wire

// *** test/als_fetch_model.sv ***
// Fetch and memory-read partner model for the accumulator slice
`default_nettype none
module als_fetch_model (
  // Clock, reset, pacing
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        slow,
  // Byte supply
  input  wire logic        byte_req,
  input  wire logic        byte_from_mem,
  input  wire logic [15:0] mem_addr,
  output logic             byte_valid,
  output logic [7:0]       byte_data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] prog [0:127]; // Instruction stream, loaded by the bench
  logic [6:0] pc;           // Next stream byte
  logic [1:0] stall;        // Wait clocks spent on this byte
  logic [7:0] last;         // Last byte handed over
  // Slow mode stretches every byte by two clocks
  assign byte_valid = byte_req && (!slow || stall == 2'd2);
  // Idle bus shows the inverse of the last byte so stale data never matches
  always_comb begin
    if (!byte_valid) begin
      byte_data = ~last;
    end else if (byte_from_mem) begin
      byte_data = mem_addr[7:0] ^ mem_addr[15:8] ^ 8'h3c;
    end else begin
      byte_data = prog[pc];
    end
  end
  // Stream pointer moves only on taken stream bytes
  always_ff @(posedge clock) begin
    if (rst) begin
      pc <= 7'd0;
      stall <= 2'd0;
      last <= 8'h00;
    end else if (byte_valid) begin
      stall <= 2'd0;
      last <= byte_data;
      if (!byte_from_mem) pc <= pc + 7'd1;
    end else if (byte_req) begin
      stall <= stall + 2'd1;
    end
  end
endmodule
`default_nettype wire

// *** test/als_core_monitor.sv ***
// Port checker for the accumulator logic slice
`default_nettype none
module als_core_monitor (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rst,
  // Byte supply
  input wire logic        byte_req,
  input wire logic        byte_from_mem,
  input wire logic [15:0] mem_addr,
  input wire logic        byte_valid,
  // Execution status
  input wire logic        retire,
  input wire logic        unsupported,
  input wire logic [7:0]  acc_out,
  input wire logic [7:0]  flags_out,
  input wire logic [2:0]  last_mcycles,
  input wire logic [7:0]  last_tstates
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Byte offered, not yet taken
  sequence s_stall;
    byte_req && !byte_valid;
  endsequence
  // Instruction of this slice retired
  sequence s_done;
    retire && !unsupported;
  endsequence
  property p_retire_pulse; retire |=> !retire; endproperty
  property p_retire_cause; retire |-> $past(byte_req) && $past(byte_valid); endproperty
  // Stalled clocks freeze the state counter, so the totals are exact
  property p_cycles;
    s_done |-> (last_mcycles == 3'd1 && last_tstates == 8'd4) ||
      (last_mcycles == 3'd2 && last_tstates == 8'd7) ||
      (last_mcycles == 3'd5 && last_tstates == 8'd19);
  endproperty
  property p_zero; s_done |-> flags_out[6] == (acc_out == 8'h00); endproperty
  property p_sign; s_done |-> flags_out[7] == acc_out[7]; endproperty
  property p_logic;
    s_done ##0 !flags_out[1] |-> !flags_out[0] && flags_out[2] == ~^acc_out;
  endproperty
  // Stretching a state must not move the request
  property p_hold;
    s_stall |=> byte_req && $stable(byte_from_mem) && $stable(mem_addr);
  endproperty
  property p_unsup; unsupported |-> retire; endproperty
  a_retire_pulse: assert property (p_retire_pulse)
    else $error("retire longer than one cycle");
  a_retire_cause: assert property (p_retire_cause)
    else $error("retire without a taken byte");
  a_cycles: assert property (p_cycles)
    else $error("bad cycle counts");
  a_zero: assert property (p_zero)
    else $error("zero flag wrong");
  a_sign: assert property (p_sign)
    else $error("sign flag wrong");
  a_logic: assert property (p_logic)
    else $error("logic op flags wrong");
  a_hold: assert property (p_hold)
    else $error("byte request moved while waiting");
  a_unsup: assert property (p_unsup)
    else $error("unsupported without retire");
endmodule
bind als_core als_core_monitor mon (
  .clock(clock), .rst(rst), .byte_req(byte_req), .byte_from_mem(byte_from_mem),
  .mem_addr(mem_addr), .byte_valid(byte_valid), .retire(retire),
  .unsupported(unsupported), .acc_out(acc_out), .flags_out(flags_out),
  .last_mcycles(last_mcycles), .last_tstates(last_tstates));
`default_nettype wire

// *** test/als_core_bench.sv ***
// Self-checking bench of the accumulator logic slice
`include "als_regs.vh"
`default_nettype none
module als_core_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock = 1'b0, rst = 1'b1, slow = 1'b0;
  logic reg_write = 1'b0, reg_read = 1'b0, byte_req, byte_from_mem, byte_valid;
  logic busy, retire, unsupported;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, reg_rdata, byte_data, acc_out, flags_out, last_tstates;
  logic [2:0] last_mcycles;
  logic [15:0] mem_addr, ix1, ix2;
  logic [7:0] regs [0:5];
  logic [7:0] acc_e, flg_e;
  logic [31:0] exp_q [$];
  int failures = 0, n_compared = 0, np;
  always #20 clock = ~clock;
  // ce tied high: freezing is not part of these rules
  als_core DUT (.clock(clock), .rst(rst), .ce(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .byte_req(byte_req), .byte_from_mem(byte_from_mem),
    .mem_addr(mem_addr), .byte_valid(byte_valid), .byte_data(byte_data), .busy(busy),
    .retire(retire), .unsupported(unsupported), .acc_out(acc_out), .flags_out(flags_out),
    .last_mcycles(last_mcycles), .last_tstates(last_tstates));
  als_fetch_model fm (.clock(clock), .rst(rst), .slow(slow), .byte_req(byte_req),
    .byte_from_mem(byte_from_mem), .mem_addr(mem_addr), .byte_valid(byte_valid),
    .byte_data(byte_data));
  // ----------------------------------------------------------------
  // Bus and compare tasks
  // ----------------------------------------------------------------
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
    @(posedge clock);
  endtask
  // Read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input string what);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1 check(what, {24'h0, reg_rdata}, {24'h0, e});
    @(posedge clock);
  endtask
  task automatic put(input logic [7:0] b);
    fm.prog[np] = b;
    np++;
  endtask
  // Append one instruction and work out its outcome; form 0 reg,1 imm,2 ptr,3/4 index
  task automatic instr(input logic [2:0] op, input int form, input logic [7:0] arg);
    logic [7:0] s, opc;
    logic [8:0] r;
    logic [4:0] h;
    logic [15:0] ea;
    int tt, mm;
    opc = {2'b10, op, 3'b110};
    ea = {regs[4], regs[5]};
    if (form == 3) ea = ix1 + {{8{arg[7]}}, arg};
    if (form == 4) ea = ix2 + {{8{arg[7]}}, arg};
    s = ea[7:0] ^ ea[15:8] ^ 8'h3c;
    if (form == 0) s = (arg == 8'h07) ? acc_e : regs[arg[2:0]];
    if (form == 0) opc[2:0] = arg[2:0];
    if (form == 1) s = arg;
    if (form == 1) opc[7:6] = 2'b11;
    if (form > 2) put(form == 3 ? `ALS_PFX_IDX1 : `ALS_PFX_IDX2);
    put(opc);
    if (form == 1 || form > 2) put(arg);
    mm = form == 0 ? 1 : form < 3 ? 2 : 5;
    tt = form == 0 ? 4 : form < 3 ? 7 : 19;
    // Wait clocks stretch the final state but never enter the clock-state total
    r = {1'b0, acc_e} - {1'b0, s} - flg_e[0];
    h = {1'b0, acc_e[3:0]} - {1'b0, s[3:0]} - flg_e[0];
    if (op == `ALS_OP_SBC) begin
      flg_e = {r[7], r[7:0] == 0, 1'b0, h[4], 1'b0,
               (acc_e[7] ^ s[7]) & (acc_e[7] ^ r[7]), 1'b1, r[8]};
    end else begin
      r[7:0] = op == `ALS_OP_AND ? acc_e & s : op == `ALS_OP_OR ? acc_e | s : acc_e ^ s;
      flg_e = {r[7], r[7:0] == 0, 1'b0, op == `ALS_OP_AND, 1'b0, ~^r[7:0], 2'b00};
    end
    acc_e = r[7:0];
    exp_q.push_back({acc_e, flg_e, mm[7:0], tt[7:0]});
  endtask
  task automatic wait_retire();
    int w;
    w = 0;
    do begin
      @(posedge clock);
      #1 w++;
    end while (retire !== 1'b1 && w < 100);
    if (w >= 100) failures++;
  endtask
  task automatic give_verdict();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // One full pass: reset, load, run every operation in every form
  // ----------------------------------------------------------------
  task automatic phase(input logic s_mode);
    logic [2:0] ops [0:3];
    ops = '{`ALS_OP_SBC, `ALS_OP_AND, `ALS_OP_XOR, `ALS_OP_OR};
    slow <= s_mode;
    rst <= 1'b1;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(`ALS_A_A, 8'h00, "acc after reset");
    regs = '{8'h11, 8'h80, 8'h7f, 8'h00, 8'h12, 8'h34};
    for (int i = 0; i < 6; i++) wr(i[3:0], regs[i]);
    ix1 = 16'h1230;
    ix2 = 16'h20f0;
    acc_e = 8'h16;
    flg_e = 8'h01;
    wr(`ALS_A_A, acc_e);
    wr(`ALS_A_F, flg_e);
    wr(`ALS_A_IX1_LO, ix1[7:0]);
    wr(`ALS_A_IX1_HI, ix1[15:8]);
    wr(`ALS_A_IX2_LO, ix2[7:0]);
    wr(`ALS_A_IX2_HI, ix2[15:8]);
    np = 0;
    exp_q.delete();
    foreach (ops[k]) begin
      for (int c = 0; c < 8; c++) if (c != 6) instr(ops[k], 0, c[7:0]);
      instr(ops[k], 1, {ops[k], 5'h0d});
      instr(ops[k], 2, 8'h00);
      instr(ops[k], 3, 8'h85);
      instr(ops[k], 4, 8'h7f);
    end
    for (int i = np; i < 128; i++) fm.prog[i] = 8'h00;
    wr(`ALS_A_CTRL, 8'h01);
    foreach (exp_q[k]) begin
      wait_retire();
      check("acc flags cycles",
            {acc_out, flags_out, 5'd0, last_mcycles,
             last_tstates}, exp_q[k]);
      check("retire kind", {31'd0, unsupported}, 32'd0);
    end
    wait_retire();
    check("opcode 00 refused", {31'd0, unsupported}, 32'd1);
    wr(`ALS_A_CTRL, 8'h00);
    for (int w = 0; w < 100 && busy !== 1'b0; w++) @(posedge clock);
    rd(`ALS_A_STATUS, 8'h02, "status sticky");
    wr(`ALS_A_STATUS, 8'h02);
    rd(`ALS_A_STATUS, 8'h00, "status cleared");
    rd(`ALS_A_A, acc_e, "acc readback");
    $display("pass with slow=%0d done", s_mode);
  endtask
  // Main sequence: fast supply, then a stalling supply
  initial begin
    phase(1'b0);
    phase(1'b1);
    give_verdict();
  end
  // Watchdog: both passes need well under 10000 clocks
  initial begin
    #1ms;
    failures++;
    give_verdict();
  end
endmodule
`default_nettype wire
